//--- phy_base_pkg.sv
// Constants, field layouts and state codes shared by both ends of the PHY register link.
// Assumes one clock for both ends and byte-wide base registers at addresses 1 to 4.

package phy_base_pkg;

  // ----------------------------------------------------------------
  // Register addresses and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_GAP = 4'h1;
  localparam logic [3:0] ADDR_CAPS = 4'h2;
  localparam logic [3:0] ADDR_SPEED = 4'h3;
  localparam logic [3:0] ADDR_LINK = 4'h4;
  localparam int BIT_LONG_RESET = 6;
  localparam int BIT_LINK_ACTIVE = 7;
  localparam int BIT_CONTENDER = 6;
  localparam logic [5:0] GAP_RESET = 6'h3F;
  localparam logic [2:0] EXTENDED_SET = 3'h7;
  localparam logic [3:0] PORT_QUANTITY = 4'h3;
  localparam logic [2:0] LEGACY_SPEED = 3'h7;
  localparam logic [3:0] REPEATER_DELAY = 4'h0;
  localparam logic [2:0] REPEATER_JITTER = 3'h0;
  localparam logic LINK_ACTIVE_RESET = 1'b1;
  localparam logic CONTENDER_RESET = 1'b0;
  localparam int SELF_ID_LINK_BIT = 9;
  localparam int SELF_ID_CONTENDER_BIT = 20;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 100;
  localparam int LONG_RESET_US = 166;
  localparam int LONG_RESET_CYCLES = LONG_RESET_US * CLOCK_MHZ;
  localparam logic [11:0] FAIR_GAP_BASE = 12'h010;
  localparam logic [11:0] FAIR_GAP_STEP = 12'h004;
  localparam logic [11:0] ARB_RESET_GAP_BASE = 12'h020;
  localparam logic [11:0] ARB_RESET_GAP_STEP = 12'h008;
  localparam logic [11:0] ARB_DELAY_BASE = 12'h008;
  localparam logic [11:0] ARB_DELAY_STEP = 12'h002;

  // ----------------------------------------------------------------
  // Controller registers on the system bus
  // ----------------------------------------------------------------
  localparam logic [7:0] HOST_CMD_OFFSET = 8'h00;
  localparam logic [7:0] HOST_STATUS_OFFSET = 8'h04;
  localparam int CMD_WRITE_BIT = 16;
  localparam int CMD_READ_BIT = 17;
  localparam int STATUS_BUSY_BIT = 0;

  typedef enum logic [1:0] {
    RST_IDLE = 2'b00,
    RST_WAIT = 2'b01,
    RST_DRIVE = 2'b10
  } reset_state_e;

  function automatic logic [11:0] gapTime(input logic [5:0] gap, input logic [11:0] base,
                                          input logic [11:0] step);
    gapTime = base + 12'(gap) * step;
  endfunction : gapTime

endpackage : phy_base_pkg

//--- phy_reg_if.sv
// Register access link between the link-layer controller and the PHY register bank.
// Assumes both ends run on the same clock; strobes last one cycle.
`timescale 1ns/1ps
`default_nettype none

interface phy_reg_if;
  logic [3:0] regAddr;
  logic [7:0] regWrData;
  logic regWrite;
  logic regRead;
  logic [7:0] regRdData;
  logic regRdValid;

  modport device (
    input regAddr,
    input regWrData,
    input regWrite,
    input regRead,
    output regRdData,
    output regRdValid
  );

  modport host (
    output regAddr,
    output regWrData,
    output regWrite,
    output regRead,
    input regRdData,
    input regRdValid
  );
endinterface : phy_reg_if

`default_nettype wire

//--- phy_base_regs.sv
// PHY base register bank with long bus reset, gap setting and self-ID flags.
// Assumes the arbiter, packet layer and controller share ref_clk; the link power pin is async.
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none

module phy_base_regs #(
  parameter int LONG_RESET_CYCLES = phy_base_pkg::LONG_RESET_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  phy_reg_if.device phy,
  input wire logic link_power_status_input,
  input wire logic rxBusy,
  input wire logic txBusy,
  input wire logic busResetIn,
  input wire logic cfgGapValid,
  input wire logic [5:0] cfgGap,
  output logic busResetActive,
  output logic [5:0] gapSetting,
  output logic [11:0] fairGapCycles,
  output logic [11:0] arbResetGapCycles,
  output logic [11:0] arbDelayCycles,
  output logic [31:0] selfIdFlags,
  output logic linkInterfaceActive
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  generate
    if (LONG_RESET_CYCLES < 1 || LONG_RESET_CYCLES > 1048575) begin : g_bad_len
      $error("LONG_RESET_CYCLES out of range.");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Link power status synchroniser
  // ----------------------------------------------------------------
  logic powerMeta;
  logic powerSync;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      powerMeta <= 1'b0;
      powerSync <= 1'b0;
    end else begin
      powerMeta <= link_power_status_input;
      powerSync <= powerMeta;
    end
  end

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  wire writeGap = phy.regWrite && (phy.regAddr == phy_base_pkg::ADDR_GAP);
  wire writeLink = phy.regWrite && (phy.regAddr == phy_base_pkg::ADDR_LINK);

  // ----------------------------------------------------------------
  // Long bus reset sequencer
  // ----------------------------------------------------------------
  phy_base_pkg::reset_state_e state;
  phy_base_pkg::reset_state_e next_state;
  logic [19:0] resetCount;
  logic longResetRequest;

  wire linkBusy = rxBusy || txBusy;
  wire lastCount = (resetCount == 20'(LONG_RESET_CYCLES - 1));
  wire startDrive = (state == phy_base_pkg::RST_WAIT) && !linkBusy;
  wire busResetEvent = startDrive || busResetIn;

  always_comb begin
    next_state = state;
    case (state)
      phy_base_pkg::RST_IDLE: begin
        if (longResetRequest) begin
          next_state = phy_base_pkg::RST_WAIT;
        end
      end
      phy_base_pkg::RST_WAIT: begin
        if (!linkBusy) begin
          next_state = phy_base_pkg::RST_DRIVE;
        end
      end
      phy_base_pkg::RST_DRIVE: begin
        if (lastCount) begin
          next_state = phy_base_pkg::RST_IDLE;
        end
      end
      default: begin
        next_state = phy_base_pkg::RST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= phy_base_pkg::RST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || state != phy_base_pkg::RST_DRIVE) begin
      resetCount <= 20'h00000;
    end else begin
      resetCount <= resetCount + 20'h00001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busResetActive <= 1'b0;
    end else begin
      busResetActive <= (next_state == phy_base_pkg::RST_DRIVE);
    end
  end

  // ----------------------------------------------------------------
  // Long-reset request bit
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      longResetRequest <= 1'b0;
    end else if (writeGap) begin
      longResetRequest <= phy.regWrData[phy_base_pkg::BIT_LONG_RESET];
    end else if (busResetEvent) begin
      longResetRequest <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration gap setting
  // ----------------------------------------------------------------
  logic resetSeenSinceUpdate;
  wire gapUpdate = writeGap || cfgGapValid;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gapSetting <= phy_base_pkg::GAP_RESET;
      resetSeenSinceUpdate <= 1'b0;
    end else if (writeGap) begin
      gapSetting <= phy.regWrData[5:0];
      resetSeenSinceUpdate <= 1'b0;
    end else if (cfgGapValid) begin
      gapSetting <= cfgGap;
      resetSeenSinceUpdate <= 1'b0;
    end else if (busResetEvent) begin
      if (resetSeenSinceUpdate) begin
        gapSetting <= phy_base_pkg::GAP_RESET;
      end
      resetSeenSinceUpdate <= 1'b1;
    end
  end

  wire [11:0] fairNext = phy_base_pkg::gapTime(gapSetting, phy_base_pkg::FAIR_GAP_BASE,
                                               phy_base_pkg::FAIR_GAP_STEP);
  wire [11:0] arbResetNext = phy_base_pkg::gapTime(gapSetting,
                                                   phy_base_pkg::ARB_RESET_GAP_BASE,
                                                   phy_base_pkg::ARB_RESET_GAP_STEP);
  wire [11:0] arbDelayNext = phy_base_pkg::gapTime(gapSetting, phy_base_pkg::ARB_DELAY_BASE,
                                                   phy_base_pkg::ARB_DELAY_STEP);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fairGapCycles <= 12'h000;
      arbResetGapCycles <= 12'h000;
      arbDelayCycles <= 12'h000;
    end else begin
      fairGapCycles <= fairNext;
      arbResetGapCycles <= arbResetNext;
      arbDelayCycles <= arbDelayNext;
    end
  end

  // ----------------------------------------------------------------
  // Link-active control and contender flag
  // ----------------------------------------------------------------
  logic linkActiveControl;
  logic contenderFlag;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      linkActiveControl <= phy_base_pkg::LINK_ACTIVE_RESET;
      contenderFlag <= phy_base_pkg::CONTENDER_RESET;
    end else if (writeLink) begin
      linkActiveControl <= phy.regWrData[phy_base_pkg::BIT_LINK_ACTIVE];
      contenderFlag <= phy.regWrData[phy_base_pkg::BIT_CONTENDER];
    end
  end

  wire [31:0] selfIdNext = (32'(linkActiveControl && powerSync)
                            << phy_base_pkg::SELF_ID_LINK_BIT)
                           | (32'(contenderFlag) << phy_base_pkg::SELF_ID_CONTENDER_BIT);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      selfIdFlags <= 32'h00000000;
      linkInterfaceActive <= 1'b0;
    end else begin
      selfIdFlags <= selfIdNext;
      linkInterfaceActive <= powerSync;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] readMux;

  always_comb begin
    readMux = 8'h00;
    case (phy.regAddr)
      phy_base_pkg::ADDR_GAP: begin
        readMux = {1'b0, longResetRequest, gapSetting};
      end
      phy_base_pkg::ADDR_CAPS: begin
        readMux = {phy_base_pkg::EXTENDED_SET, 1'b0, phy_base_pkg::PORT_QUANTITY};
      end
      phy_base_pkg::ADDR_SPEED: begin
        readMux = {phy_base_pkg::LEGACY_SPEED, 1'b0,
                   phy_base_pkg::REPEATER_DELAY};
      end
      phy_base_pkg::ADDR_LINK: begin
        readMux = {linkActiveControl, contenderFlag, phy_base_pkg::REPEATER_JITTER,
                   3'h0};
      end
      default: begin
        readMux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phy.regRdData <= 8'h00;
      phy.regRdValid <= 1'b0;
    end else begin
      phy.regRdValid <= phy.regRead;
      if (phy.regRead) begin
        phy.regRdData <= readMux;
      end
    end
  end

endmodule : phy_base_regs

`default_nettype wire

//--- phy_link_ctrl.sv
// Link-side controller: AHB-Lite slave that issues PHY register accesses.
// Assumes one AHB-Lite master, word transfers only, and the PHY on the same clock.
`timescale 1ns/1ps
`default_nettype none

module phy_link_ctrl (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  phy_reg_if.host phy
);

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  logic dataWrite;
  logic [7:0] dataAddr;
  logic busy;
  logic [7:0] lastRead;

  wire addrPhase = hsel && hready && htrans[1];
  wire cmdWrite = dataWrite && (dataAddr == phy_base_pkg::HOST_CMD_OFFSET);
  wire startWrite = cmdWrite && !busy && hwdata[phy_base_pkg::CMD_WRITE_BIT];
  wire startRead = cmdWrite && !busy && hwdata[phy_base_pkg::CMD_READ_BIT] &&
                   !hwdata[phy_base_pkg::CMD_WRITE_BIT];
  wire readCmd = addrPhase && !hwrite && (haddr[7:0] == phy_base_pkg::HOST_CMD_OFFSET);
  wire readStatus = addrPhase && !hwrite && (haddr[7:0] == phy_base_pkg::HOST_STATUS_OFFSET);
  wire [31:0] statusWord = {16'h0000, lastRead, 7'h00, busy};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dataWrite <= 1'b0;
      dataAddr <= 8'h00;
    end else begin
      dataWrite <= addrPhase && hwrite;
      dataAddr <= haddr[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (readStatus) begin
        hrdata <= statusWord;
      end else if (readCmd) begin
        hrdata <= {20'h00000, phy.regWrData, phy.regAddr};
      end else if (addrPhase) begin
        hrdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // PHY register access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phy.regAddr <= 4'h0;
      phy.regWrData <= 8'h00;
      phy.regWrite <= 1'b0;
      phy.regRead <= 1'b0;
      busy <= 1'b0;
      lastRead <= 8'h00;
    end else begin
      phy.regWrite <= startWrite;
      phy.regRead <= startRead;
      if (startWrite || startRead) begin
        phy.regAddr <= hwdata[3:0];
        phy.regWrData <= hwdata[15:8];
      end
      if (startRead) begin
        busy <= 1'b1;
      end else if (phy.regRdValid) begin
        busy <= 1'b0;
        lastRead <= phy.regRdData;
      end
    end
  end

endmodule : phy_link_ctrl

`default_nettype wire

//--- phy_base_assertions.sv
// Concurrent checks on the register link between the controller and the PHY register bank.
// Assumes the link signals, ref_clk and the synchronous reset are handed in as plain inputs.
`timescale 1ns/1ps
`default_nettype none

module phy_base_assertions (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Last value written to the link register, seeded with its reset value.
  logic [7:0] lastLink;
  wire linkWrite = regWrite && (regAddr == phy_base_pkg::ADDR_LINK);
  wire capsRead = regRead && (regAddr == phy_base_pkg::ADDR_CAPS);
  wire speedRead = regRead && (regAddr == phy_base_pkg::ADDR_SPEED);
  wire linkRead = regRead && (regAddr == phy_base_pkg::ADDR_LINK);
  wire openRead = regRead && (regAddr > 4'h4);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lastLink <= 8'h80;
    end else if (linkWrite) begin
      lastLink <= regWrData;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  read_answered_a: assert property (regRead |=> regRdValid)
    else $error("read strobe not answered next cycle");
  valid_has_cause_a: assert property ($rose(regRdValid) |-> $past(regRead))
    else $error("read valid without a read strobe");
  valid_pulse_a: assert property (regRdValid && !regRead |=> !regRdValid)
    else $error("read valid longer than one cycle");
  caps_value_a: assert property (capsRead |=> regRdData == 8'hE3)
    else $error("capability register value wrong");
  speed_delay_a: assert property (speedRead |=> regRdData == 8'hE0)
    else $error("speed and delay register value wrong");
  jitter_zero_a: assert property (linkRead |=> regRdData[5:0] == 6'h00)
    else $error("jitter field not zero");
  link_bits_kept_a: assert property (
    linkRead |=> regRdData[7:6] == lastLink[7:6])
    else $error("link active or contender bit lost");
  unused_reads_zero_a: assert property (openRead |=> regRdData == 8'h00)
    else $error("unused register not zero");
  data_held_a: assert property (!regRdValid [*2] |-> $stable(regRdData))
    else $error("read data changed without a read");
endmodule : phy_base_assertions

`default_nettype wire

//--- testbench.sv
// Self-checking bench: AHB-Lite master driving the controller, which drives the PHY bank.
// Assumes a 100 MHz ref_clk and a shortened long-reset count for simulation.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int LONG_CYCLES = 20;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic linkPower = 1'b1;
  logic rxBusy = 1'b0;
  logic txBusy = 1'b0;
  logic busResetIn = 1'b0;
  logic cfgGapValid = 1'b0;
  logic [5:0] cfgGap = 6'h00;
  logic busResetActive;
  logic [5:0] gapSetting;
  logic [11:0] fairGapCycles;
  logic [11:0] arbResetGapCycles;
  logic [11:0] arbDelayCycles;
  logic [31:0] selfIdFlags;
  logic linkInterfaceActive;
  logic [31:0] rd;
  int num_errors = 0;
  int n_compared = 0;
  int cnt;

  assign hready = hreadyout;
  always #5 ref_clk = ~ref_clk;

  phy_reg_if phy ();
  phy_base_regs #(.LONG_RESET_CYCLES(LONG_CYCLES)) u_phy_base_regs (.ref_clk(ref_clk),
    .reset(reset), .phy(phy), .link_power_status_input(linkPower), .rxBusy(rxBusy),
    .txBusy(txBusy), .busResetIn(busResetIn), .cfgGapValid(cfgGapValid), .cfgGap(cfgGap),
    .busResetActive(busResetActive), .gapSetting(gapSetting), .fairGapCycles(fairGapCycles),
    .arbResetGapCycles(arbResetGapCycles), .arbDelayCycles(arbDelayCycles),
    .selfIdFlags(selfIdFlags), .linkInterfaceActive(linkInterfaceActive));
  phy_link_ctrl u_phy_link_ctrl (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .phy(phy));
  phy_base_assertions u_phy_base_assertions (.ref_clk(ref_clk), .reset(reset),
    .regAddr(phy.regAddr), .regWrData(phy.regWrData), .regWrite(phy.regWrite),
    .regRead(phy.regRead), .regRdData(phy.regRdData), .regRdValid(phy.regRdValid));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ahbXfer(input logic [31:0] a, input logic wr, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
    check(hresp, 32'h0);
  endtask : ahbXfer

  task automatic phyWrite(input logic [3:0] a, input logic [7:0] d);
    ahbXfer(32'h0, 1'b1, 32'h0001_0000 | {16'h0, d, 4'h0, a});
    repeat (4) @(posedge ref_clk);
  endtask : phyWrite

  task automatic phyRead(input logic [3:0] a, input logic [7:0] exp);
    ahbXfer(32'h0, 1'b1, 32'h0002_0000 | {28'h0, a});
    repeat (3) @(posedge ref_clk);
    cnt = 0;
    do begin
      ahbXfer(32'h4, 1'b0, 32'h0);
      cnt++;
    end while (rd[0] !== 1'b0 && cnt < 20);
    check({31'h0, rd[0]}, 32'h0);
    check({24'h0, rd[15:8]}, {24'h0, exp});
  endtask : phyRead

  task automatic checkGap(input logic [5:0] g);
    check(gapSetting, g);
    check(fairGapCycles, phy_base_pkg::FAIR_GAP_BASE + g * phy_base_pkg::FAIR_GAP_STEP);
    check(arbResetGapCycles,
          phy_base_pkg::ARB_RESET_GAP_BASE + g * phy_base_pkg::ARB_RESET_GAP_STEP);
    check(arbDelayCycles,
          phy_base_pkg::ARB_DELAY_BASE + g * phy_base_pkg::ARB_DELAY_STEP);
  endtask : checkGap

  task automatic pulseBusReset();
    @(posedge ref_clk);
    busResetIn <= 1'b1;
    @(posedge ref_clk);
    busResetIn <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : pulseBusReset

  task automatic print_verdict();
    $display("Comparisons %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    phyRead(4'h1, 8'h3F);
    checkGap(6'h3F);
    phyRead(4'h2, 8'hE3);
    phyRead(4'h3, 8'hE0);
    phyRead(4'h4, 8'h80);
    phyRead(4'h6, 8'h00);
    ahbXfer(32'h8, 1'b0, 32'h0);
    check(rd, 32'h0);
    check(selfIdFlags, 32'h0000_0200);
    phyWrite(4'h4, 8'h40);
    check(selfIdFlags, 32'h0010_0000);
    check(linkInterfaceActive, 32'h1);
    ahbXfer(32'h0, 1'b0, 32'h0);
    check(rd, 32'h0000_0404);
    phyRead(4'h4, 8'h40);
    phyWrite(4'h4, 8'hC0);
    linkPower <= 1'b0;
    repeat (5) @(posedge ref_clk);
    check(linkInterfaceActive, 32'h0);
    check(selfIdFlags, 32'h0010_0000);
    linkPower <= 1'b1;
    repeat (5) @(posedge ref_clk);
    check(selfIdFlags, 32'h0010_0200);
    pulseBusReset();
    phyRead(4'h4, 8'hC0);
    phyWrite(4'h1, 8'h05);
    checkGap(6'h05);
    @(posedge ref_clk);
    cfgGapValid <= 1'b1;
    cfgGap <= 6'h0A;
    @(posedge ref_clk);
    cfgGapValid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    checkGap(6'h0A);
    pulseBusReset();
    checkGap(6'h0A);
    pulseBusReset();
    checkGap(6'h3F);
    rxBusy <= 1'b1;
    txBusy <= 1'b1;
    phyWrite(4'h1, 8'h7F);
    repeat (10) begin
      @(posedge ref_clk);
      check(busResetActive, 32'h0);
    end
    rxBusy <= 1'b0;
    repeat (5) begin
      @(posedge ref_clk);
      check(busResetActive, 32'h0);
    end
    txBusy <= 1'b0;
    cnt = 0;
    do begin
      @(posedge ref_clk);
      cnt++;
    end while (busResetActive !== 1'b1 && cnt < 50);
    cnt = 0;
    while (busResetActive === 1'b1 && cnt < 100) begin
      @(posedge ref_clk);
      cnt++;
    end
    check(cnt, LONG_CYCLES);
    phyRead(4'h1, 8'h3F);
    phyWrite(4'h1, 8'h05);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    phyRead(4'h1, 8'h3F);
    checkGap(6'h3F);
    phyRead(4'h4, 8'h80);
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
